// *** hdl/scmc_top.sv ***
// system clock source, divider, power modes and register slave
`timescale 1ns/1ps
module scmc_top
  import scmc_pkg::*;
#(
  parameter bit USE_CRYSTAL = 1'b0,
  parameter int ADDR_W = 4
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu power requests
  input wire logic halt_i,
  input wire logic wake_i,
  // oscillator pins
  input wire logic fast_rc_clk_i,
  input wire logic sub_clk_i,
  // oscillator controls
  output logic fast_osc_en_o,
  output logic sub_osc_en_o,
  output logic crystal_low_power_o,
  output logic [1:0] fast_rc_freq_o,
  // clocks and mode status
  output logic sys_clk_o,
  output logic cpu_run_o,
  output logic watchdog_en_o,
  output logic [1:0] power_mode_o
);

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] fast_sync;
  logic [1:0] sub_sync;
  logic fast_last;
  logic sub_last;
  logic fast_edge;
  logic sub_edge;
  logic fast_rise;
  logic sub_rise;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fast_sync <= 2'h0;
      sub_sync <= 2'h0;
      fast_last <= 1'b0;
      sub_last <= 1'b0;
    end
    else
    begin
      fast_sync <= {fast_sync[0], fast_rc_clk_i};
      sub_sync <= {sub_sync[0], sub_clk_i};
      fast_last <= fast_sync[1];
      sub_last <= sub_sync[1];
    end
  end

  always_comb
  begin
    fast_edge = fast_sync[1] ^ fast_last;
    sub_edge = sub_sync[1] ^ sub_last;
    fast_rise = fast_sync[1] & ~fast_last;
    sub_rise = sub_sync[1] & ~sub_last;
  end

  // ----------------------------------------------------------------------------
  // registers and power state
  // ----------------------------------------------------------------------------
  scmc_mode_t mode;
  scmc_mode_t next_mode;
  scmc_ctrl_t ctrl;
  scmc_ctrl_t next_ctrl;
  scmc_state_t state;
  scmc_state_t next_state;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic slow_ready;
  logic fast_ready;
  logic wr_hit;
  logic [7:0] wbyte;
  logic [1:0] widx;
  logic map_hit;

  always_comb
  begin
    widx = wb_adr_i[3:2];
    map_hit = (ADDR_W <= 4 || (wb_adr_i >> 4) == '0) &&
      (widx == SCMC_MODE_IDX || widx == SCMC_CTRL_IDX);
    wr_hit = wb_cyc_i && wb_stb_i && !ack && wb_we_i && wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    next_ack = wb_cyc_i && wb_stb_i && !ack;
    next_mode = mode;
    next_ctrl = ctrl;
    next_rdata = 32'h0;
    if (wr_hit && map_hit && widx == SCMC_MODE_IDX)
    begin
      next_mode.clock_divider_field = wbyte[7:5];
      next_mode.idle_enable = wbyte[1];
      next_mode.fast_select = wbyte[0];
    end
    if (wr_hit && map_hit && widx == SCMC_CTRL_IDX)
    begin
      next_ctrl = scmc_ctrl_t'(wbyte & SCMC_CTRL_WMASK);
    end
    if (!USE_CRYSTAL)
    begin
      next_ctrl.crystal_low_power = 1'b0;
    end
    next_mode.unused4 = 1'b0;
    next_mode.slow_osc_ready = slow_ready;
    next_mode.fast_osc_ready = fast_ready;
    if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i && map_hit)
    begin
      if (widx == SCMC_MODE_IDX)
      begin
        next_rdata = {24'h0, mode};
      end
      else
      begin
        next_rdata = {24'h0, ctrl};
      end
    end
    next_state = state;
    unique case (state)
      SCMC_RUN:
      begin
        if (halt_i)
        begin
          if (!mode.idle_enable)
          begin
            next_state = SCMC_SLEEP;
          end
          else if (!ctrl.idle_sysclk_keep)
          begin
            next_state = SCMC_IDLE_SUB;
          end
          else
          begin
            next_state = SCMC_IDLE_SYS;
          end
        end
      end
      SCMC_SLEEP, SCMC_IDLE_SUB, SCMC_IDLE_SYS:
      begin
        if (wake_i)
        begin
          next_state = SCMC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode <= scmc_mode_t'(SCMC_MODE_RST);
      ctrl <= scmc_ctrl_t'(SCMC_CTRL_RST);
      state <= SCMC_RUN;
      ack <= 1'b0;
      rdata <= 32'h0;
    end
    else
    begin
      mode <= next_mode;
      ctrl <= next_ctrl;
      state <= next_state;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // source request and oscillator enables
  // ----------------------------------------------------------------------------
  scmc_src_t req_src;
  scmc_src_t active;
  scmc_src_t next_active;
  logic fast_needed;

  always_comb
  begin
    req_src.use_sub = 1'b0;
    req_src.ratio = 8'h01;
    if (mode.fast_select)
    begin
      req_src.ratio = 8'h01;
    end
    else if (mode.clock_divider_field <= SCMC_CKS_SUB1)
    begin
      req_src.use_sub = 1'b1;
      req_src.ratio = SCMC_RATIO_SUB;
    end
    else
    begin
      req_src.ratio = 8'(9'h100 >> mode.clock_divider_field);
    end
    fast_needed = !req_src.use_sub || !active.use_sub;
    fast_osc_en_o = fast_needed && (state == SCMC_RUN || state == SCMC_IDLE_SYS);
    sub_osc_en_o = (state != SCMC_SLEEP);
    watchdog_en_o = (state != SCMC_SLEEP);
    cpu_run_o = (state == SCMC_RUN);
    power_mode_o = state;
    crystal_low_power_o = ctrl.crystal_low_power;
    fast_rc_freq_o = (ctrl.fast_rc_freq_field == SCMC_FREQ_8M_ALT) ?
      SCMC_FREQ_8M : ctrl.fast_rc_freq_field;
    wb_ack_o = ack;
    wb_dat_o = rdata;
  end

  // ----------------------------------------------------------------------------
  // oscillator ready counters
  // ----------------------------------------------------------------------------
  localparam int SLOW_TARGET = USE_CRYSTAL ? SCMC_XTAL_READY_CYCLES : SCMC_SLOW_INTERNAL_RC_READY_CYCLES;
  logic [10:0] slow_cnt;
  logic [10:0] next_slow_cnt;
  logic [4:0] fast_cnt;
  logic [4:0] next_fast_cnt;
  logic next_slow_ready;
  logic next_fast_ready;

  always_comb
  begin
    next_slow_cnt = slow_cnt;
    next_slow_ready = slow_ready;
    next_fast_cnt = fast_cnt;
    next_fast_ready = fast_ready;
    if (!sub_osc_en_o)
    begin
      next_slow_cnt = 11'h000;
      next_slow_ready = 1'b0;
    end
    else if (!slow_ready && sub_rise)
    begin
      next_slow_cnt = slow_cnt + 11'h001;
      if (slow_cnt == 11'(SLOW_TARGET - 1))
      begin
        next_slow_ready = 1'b1;
      end
    end
    if (!fast_osc_en_o)
    begin
      next_fast_cnt = 5'h00;
      next_fast_ready = 1'b0;
    end
    else if (!fast_ready && fast_rise)
    begin
      next_fast_cnt = fast_cnt + 5'h01;
      if (fast_cnt == 5'(SCMC_FAST_INTERNAL_RC_READY_CYCLES - 1))
      begin
        next_fast_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      slow_cnt <= 11'h000;
      slow_ready <= 1'b0;
      fast_cnt <= 5'h00;
      fast_ready <= 1'b0;
    end
    else
    begin
      slow_cnt <= next_slow_cnt;
      slow_ready <= next_slow_ready;
      fast_cnt <= next_fast_cnt;
      fast_ready <= next_fast_ready;
    end
  end

  // ----------------------------------------------------------------------------
  // glitch-free divider and source switch
  // ----------------------------------------------------------------------------
  logic sys_clk;
  logic next_sys_clk;
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic src_edge;
  logic new_ready;
  logic clk_allowed;

  always_comb
  begin
    next_active = active;
    next_div_cnt = div_cnt;
    next_sys_clk = sys_clk;
    src_edge = active.use_sub ? sub_edge : fast_edge;
    new_ready = req_src.use_sub ? slow_ready : fast_ready;
    clk_allowed = (state == SCMC_RUN) || (state == SCMC_IDLE_SYS);
    if (!sys_clk && req_src != active && new_ready)
    begin
      next_active = req_src;
      next_div_cnt = 8'h00;
    end
    else if (src_edge && (clk_allowed || sys_clk))
    begin
      if (div_cnt >= active.ratio - 8'h01)
      begin
        next_div_cnt = 8'h00;
        next_sys_clk = !sys_clk && clk_allowed;
      end
      else
      begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      active <= '{use_sub: 1'b0, ratio: 8'h01};
      div_cnt <= 8'h00;
      sys_clk <= 1'b0;
    end
    else
    begin
      active <= next_active;
      div_cnt <= next_div_cnt;
      sys_clk <= next_sys_clk;
    end
  end

  assign sys_clk_o = sys_clk;

endmodule

// *** hdl/scmc_pkg.sv ***
// package for the system clock and power-mode controller
// ----------------------------------------------------------------------------
// Functional notes
// - crystal low-power bit clears at power-on, so the crystal quick-starts.
// - crystal keeps running in either power setting; only current differs.
// - switching system clock to sub-clock stops the fast oscillator.
// - sub-clock source is slow RC or crystal, a static build option.
// - normal mode runs the CPU from fast RC divided by 1 to 64.
// - slow mode clocks the CPU from sub-clock with fast clock off.
// - halt with idle-enable low enters sleep: CPU, clocks, watchdog stop.
// - halt with idle-enable high, keep bit low: CPU and system clock stop.
// - halt with idle-enable and keep bit high: only the CPU stops.
// - clock field 000/001 pick sub-clock; 010..111 pick fast/64 down to /2.
// - fast-select high uses undivided fast clock, ignoring the clock field.
// - slow ready low in sleep; rises after 1024 crystal or 1-2 RC cycles.
// - fast ready cleared at power-on, low in sleep/idle_sub_only_mode, up in 15-16 cycles.
// - mode register: field 7:5, bit 4 zero, flags 3:2 read-only, 1:0 reset 1.
// - control register: keep 7, zero 6, freq 5:4, crystal 3, flag 2, spare 1.
// - fast RC freq field: 00 8 MHz, 01 12 MHz, 10 16 MHz, 11 8 MHz.
// - crystal low-power bit only acts on builds with the crystal.
// ----------------------------------------------------------------------------
package scmc_pkg;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam logic [1:0] SCMC_MODE_IDX = 2'h0;
  localparam logic [1:0] SCMC_CTRL_IDX = 2'h1;
  localparam logic [7:0] SCMC_MODE_RST = 8'h03;
  localparam logic [7:0] SCMC_CTRL_RST = 8'h00;
  localparam logic [7:0] SCMC_CTRL_WMASK = 8'hBF;

  // ----------------------------------------------------------------------------
  // field codes and counts
  // ----------------------------------------------------------------------------
  localparam logic [2:0] SCMC_CKS_SUB1 = 3'h1;
  localparam logic [1:0] SCMC_FREQ_8M = 2'h0;
  localparam logic [1:0] SCMC_FREQ_12M = 2'h1;
  localparam logic [1:0] SCMC_FREQ_16M = 2'h2;
  localparam logic [1:0] SCMC_FREQ_8M_ALT = 2'h3;
  localparam int SCMC_XTAL_READY_CYCLES = 1024;
  localparam int SCMC_SLOW_INTERNAL_RC_READY_CYCLES = 1;
  localparam int SCMC_FAST_INTERNAL_RC_READY_CYCLES = 15;
  localparam logic [7:0] SCMC_RATIO_SUB = 8'h01;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clock_divider_field;
    logic unused4;
    logic slow_osc_ready;
    logic fast_osc_ready;
    logic idle_enable;
    logic fast_select;
  } scmc_mode_t;

  typedef struct packed {
    logic idle_sysclk_keep;
    logic unused6;
    logic [1:0] fast_rc_freq_field;
    logic crystal_low_power;
    logic low_voltage_reset_flag;
    logic spare;
    logic watchdog_ctl_reset_flag;
  } scmc_ctrl_t;

  typedef enum logic [1:0] {
    SCMC_RUN = 2'b00,
    SCMC_SLEEP = 2'b01,
    SCMC_IDLE_SUB = 2'b10,
    SCMC_IDLE_SYS = 2'b11
  } scmc_state_t;

  typedef struct packed {
    logic use_sub;
    logic [7:0] ratio;
  } scmc_src_t;

endpackage

// *** test/scmc_osc.sv ***
// oscillator model driving the fast and sub clock pins
`timescale 1ns/1ps
module scmc_osc
(
  // enables from the controller
  input wire logic fast_en_i,
  input wire logic sub_en_i,
  // oscillator pins
  output logic fast_clk_o = 1'b0,
  output logic sub_clk_o = 1'b0
);
  // fast rc parks low while disabled
  always #70 fast_clk_o = fast_en_i ? ~fast_clk_o : 1'b0;
  // sub clock ignores the crystal power setting
  always #230 sub_clk_o = sub_en_i ? ~sub_clk_o : 1'b0;
endmodule

// *** test/scmc_asserts.sv ***
// port assertions for the clock and power-mode controller
`timescale 1ns/1ps
module scmc_asserts
  import scmc_pkg::*;
#(
  parameter bit USE_CRYSTAL = 1'b0
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // bus and requests
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic halt_i,
  input wire logic wake_i,
  // status
  input wire logic sub_osc_en_o,
  input wire logic crystal_low_power_o,
  input wire logic [1:0] fast_rc_freq_o,
  input wire logic sys_clk_o,
  input wire logic cpu_run_o,
  input wire logic watchdog_en_o,
  input wire logic [1:0] power_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence halted;
    halt_i && !wake_i && power_mode_o == SCMC_RUN;
  endsequence
  sequence parked;
    (power_mode_o inside {SCMC_SLEEP, SCMC_IDLE_SUB}) && !sys_clk_o && !wake_i;
  endsequence
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_halt_leaves: assert property (halted |=> power_mode_o != SCMC_RUN && !cpu_run_o)
    else $error("halt ignored");
  a_sleep_stops: assert property (power_mode_o == SCMC_SLEEP |->
    !cpu_run_o && !watchdog_en_o && !sub_osc_en_o)
    else $error("sleep leaves something running");
  a_idle_sub: assert property (power_mode_o == SCMC_IDLE_SUB |->
    sub_osc_en_o && watchdog_en_o && !cpu_run_o)
    else $error("idle_sub_only_mode outputs wrong");
  a_clk_parked: assert property (parked |=> !sys_clk_o[*2])
    else $error("system clock runs while stopped");
  a_idle_sys: assert property (power_mode_o == SCMC_IDLE_SYS |-> sub_osc_en_o && !cpu_run_o)
    else $error("idle_sysclk_on_mode outputs wrong");
  a_wake_run: assert property (wake_i |=> power_mode_o == SCMC_RUN && cpu_run_o)
    else $error("wake did not return to run");
  a_freq_code: assert property (fast_rc_freq_o != 2'h3)
    else $error("frequency code out of range");
  a_xtal_gate: assert property (!USE_CRYSTAL |-> !crystal_low_power_o)
    else $error("crystal power bit active without crystal");
endmodule

// *** test/scmc_top_tb.sv ***
// bench for the clock and power-mode controller
`timescale 1ns/1ps
module scmc_top_tb
  import scmc_pkg::*;
;
  logic clk_i = 1'b0, nrst_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic halt_i = 1'b0, wake_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, fast_rc_clk_i, sub_clk_i, fast_osc_en_o, sub_osc_en_o;
  logic crystal_low_power_o, sys_clk_o, cpu_run_o, watchdog_en_o;
  logic [1:0] fast_rc_freq_o, power_mode_o;
  logic [7:0] q;
  int failures = 0, n_tests = 0, rises = 0, i;
  logic [7:0] mode_tab [9] = '{8'h43, 8'hE2, 8'hC2, 8'hA2, 8'h82, 8'h62, 8'h42, 8'h02, 8'h22};
  int rat [9] = '{1, 2, 4, 8, 16, 32, 64, 1, 1};
  always #10 clk_i = ~clk_i;
  always @(posedge sys_clk_o) rises++;
  scmc_top DUT (.clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .halt_i, .wake_i, .fast_rc_clk_i, .sub_clk_i,
    .fast_osc_en_o, .sub_osc_en_o, .crystal_low_power_o, .fast_rc_freq_o, .sys_clk_o,
    .cpu_run_o, .watchdog_en_o, .power_mode_o);
  scmc_osc OSC (.fast_en_i(fast_osc_en_o), .sub_en_i(sub_osc_en_o),
    .fast_clk_o(fast_rc_clk_i), .sub_clk_o(sub_clk_i));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(q, e);
  endtask
  task automatic edges(input bit s, input int n);
    repeat (n)
      if (s)
        @(posedge sub_clk_i);
      else
        @(posedge fast_rc_clk_i);
  endtask
  task automatic rate(input logic [7:0] m, input int r, input bit s);
    int c0;
    int d;
    wb(1'b1, 4'h0, m);
    edges(s, 64);
    c0 = rises;
    edges(s, 256);
    d = rises - c0 - 256 / r;
    check(32'(d * d <= 1), 32'h1);
  endtask
  task automatic power(input logic [7:0] m, input logic [7:0] c, input logic [1:0] st,
    input logic [7:0] rm);
    int c0;
    wb(1'b1, 4'h0, m);
    wb(1'b1, 4'h4, c);
    @(posedge clk_i);
    halt_i <= 1'b1;
    @(posedge clk_i);
    halt_i <= 1'b0;
    #1;
    check(power_mode_o, st);
    check(cpu_run_o, 1'b0);
    check(watchdog_en_o, st != SCMC_SLEEP);
    check(sub_osc_en_o, st != SCMC_SLEEP);
    repeat (100) @(posedge clk_i);
    c0 = rises;
    repeat (100) @(posedge clk_i);
    check(rises != c0, st == SCMC_IDLE_SYS);
    rd(4'h0, rm);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (400) @(posedge clk_i);
    check(cpu_run_o, 1'b1);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, 8'h03);
    rd(4'h4, 8'h00);
    check(crystal_low_power_o, 1'b0);
    $display("reset test done");
    repeat (300) @(posedge clk_i);
    rd(4'h0, 8'h0F);
    wb(1'b1, 4'h0, 8'hFF);
    rd(4'h0, 8'hEF);
    wb(1'b1, 4'h4, 8'hFF);
    rd(4'h4, 8'hB7);
    check(crystal_low_power_o, 1'b0);
    rd(4'h8, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wb(1'b1, 4'h4, 8'(i << 4));
      check(fast_rc_freq_o, (i == 3) ? 2'h0 : 2'(i));
    end
    $display("register test done");
    for (i = 0; i < 9; i++)
      rate(mode_tab[i], rat[i], i > 6);
    check(fast_osc_en_o, 1'b0);
    rd(4'h0, 8'h2A);
    rate(8'h03, 1, 1'b0);
    rd(4'h0, 8'h0F);
    $display("clock test done");
    power(8'h01, 8'h00, SCMC_SLEEP, 8'h01);
    power(8'h03, 8'h00, SCMC_IDLE_SUB, 8'h0B);
    power(8'h03, 8'h80, SCMC_IDLE_SYS, 8'h0F);
    $display("power test done");
    stop_test();
  end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    stop_test();
  end
endmodule
bind scmc_top scmc_asserts #(.USE_CRYSTAL(USE_CRYSTAL)) u_chk (.clk_i, .nrst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .halt_i, .wake_i, .sub_osc_en_o, .crystal_low_power_o,
  .fast_rc_freq_o, .sys_clk_o, .cpu_run_o, .watchdog_en_o, .power_mode_o);
